// ### pkg/cap_pkg.sv
package cap_pkg;

  // ------------------------------------------------------------
  // register offsets (byte addresses, 16-bit bus)
  // ------------------------------------------------------------
  localparam logic [6:0] OFS_CTR   = 7'h00;
  localparam logic [6:0] OFS_PHS   = 7'h04;
  localparam logic [6:0] OFS_SLOT1 = 7'h08;
  localparam logic [6:0] OFS_SLOT2 = 7'h0c;
  localparam logic [6:0] OFS_SLOT3 = 7'h10;
  localparam logic [6:0] OFS_SLOT4 = 7'h14;
  localparam logic [6:0] OFS_CTL1  = 7'h28;
  localparam logic [6:0] OFS_CTL2  = 7'h2a;
  localparam logic [6:0] OFS_IEN   = 7'h2c;
  localparam logic [6:0] OFS_FLG   = 7'h2e;
  localparam logic [6:0] OFS_CLR   = 7'h30;
  localparam logic [6:0] OFS_FRC   = 7'h32;
  localparam logic [6:0] OFS_REV   = 7'h5c;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTL1_LDEN_BIT  = 8;
  localparam int CTL2_RUN_BIT   = 4;
  localparam int CTL2_SYNC_INPUT_EVENT_BIT = 5;
  localparam int CTL2_SYNCO_LSB = 6;
  localparam int CTL2_SWSYN_BIT = 8;
  localparam int CTL2_MODE_BIT  = 9;
  localparam int CTL2_POL_BIT   = 10;
  localparam int FLG_EVT_LSB    = 1;
  localparam int FLG_OVF_BIT    = 5;
  localparam int FLG_PRD_BIT    = 6;
  localparam int FLG_CMP_BIT    = 7;

  localparam logic [1:0]  SYNCO_PASS = 2'h0;
  localparam logic [1:0]  SYNCO_PRD  = 2'h1;

  // ------------------------------------------------------------
  // reset values and the control-2 write mask
  // ------------------------------------------------------------
  localparam logic [31:0] REG_RST = 32'h0;
  localparam logic [15:0] CTL_RST = 16'h0;
  localparam logic [15:0] CTL2_WMASK = 16'h06f0;

  typedef enum logic [3:0] {
    PTR_EV1 = 4'b0001,
    PTR_EV2 = 4'b0010,
    PTR_EV3 = 4'b0100,
    PTR_EV4 = 4'b1000
  } cap_ptr_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } cap_bus_req_type;

  typedef struct packed {
    logic [31:0]       ctr;
    logic [31:0]       phs;
    logic [3:0][31:0]  slot;
    logic [15:0]       ctl1;
    logic [15:0]       ctl2;
    logic [15:0]       ien;
    logic [15:0]       flg;
    cap_ptr_type       ptr;
    logic [2:0]        cap_sy;
    logic [2:0]        syn_sy;
    logic [15:0]       rdata;
    logic              pwm;
    logic              sync;
  } cap_state_type;

endpackage

// ### rtl/cap_unit.sv
`timescale 1ns/100ps
// Functional notes
// - in pwm mode a write to the active period or compare slot also lands in its shadow slot.
// - in pwm mode writes to slots three and four only load shadows, never the active values.
// - with active-high polarity the output is high for compare-value counts of each period.
// - with active-low polarity the compare value gives the low time instead.
// - with the period sync source, a sync pulse leaves whenever the running pwm-mode counter equals the period.
// - each of the four capture events uses its own edge polarity.
// - 32-bit registers are two 16-bit halves, low half at the lower address.
// - counter, phase and the four slots decode at 0h, 4h, 8h, Ch, 10h and 14h.
// - control, enable, flag, clear and force decode at 28h to 32h, revision at 5Ch.
// - in delta capture the counter is stored and cleared, and the event pointer advances, all in the same cycle.
// - the phase offset loads into the counter on a sync-in event or a software force.
// - in pwm mode slot one is the active period.
module cap_unit
  import cap_pkg::*;
#(
  parameter logic [31:0] REVISION = 32'h0000_0101  // arbitrary value
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // register port
  input  wire cap_pkg::cap_bus_req_type bus_i,
  output logic [15:0]                   rdata_o,
  // pins
  input  wire logic                     capture_input_i,
  input  wire logic                     sync_input_event_i,
  output logic                          pwm_output_pin_o,
  output logic                          sync_output_o
);
  import cap_pkg::*;

  // ------------------------------------------------------------
  // decode and event qualification
  // ------------------------------------------------------------
  cap_state_type s;
  cap_state_type next_s;
  logic [6:0]    a32;
  logic [6:0]    a16;
  logic          hi;
  logic          pwm_mode;
  logic          run;
  logic          prd_hit;
  logic [1:0]    ptr_idx;
  logic          ev_pol;
  logic          ev_rst;
  logic          rise;
  logic          fall;
  logic          evt;
  logic          sync_evt;
  logic          sync_load;
  logic          wr_ctr;

  assign a32      = {bus_i.addr[6:2], 2'b00};
  assign a16      = {bus_i.addr[6:1], 1'b0};
  assign hi       = bus_i.addr[1];
  assign pwm_mode = s.ctl2[CTL2_MODE_BIT];
  assign run      = s.ctl2[CTL2_RUN_BIT];
  assign prd_hit  = pwm_mode && run && (s.ctr == s.slot[0]);
  assign ptr_idx  = {s.ptr[3] | s.ptr[2], s.ptr[3] | s.ptr[1]};
  // polarity and clear bits sit in pairs per event
  assign ev_pol   = s.ctl1[{ptr_idx, 1'b0}];
  assign ev_rst   = s.ctl1[{ptr_idx, 1'b1}];
  assign rise     = s.cap_sy[1] & ~s.cap_sy[2];
  assign fall     = ~s.cap_sy[1] & s.cap_sy[2];
  assign evt      = !pwm_mode && run && (ev_pol ? fall : rise);
  assign sync_evt = s.syn_sy[1] & ~s.syn_sy[2];
  assign wr_ctr   = bus_i.wr && (a32 == OFS_CTR);
  assign sync_load = (sync_evt && s.ctl2[CTL2_SYNC_INPUT_EVENT_BIT])
                  || (bus_i.wr && (a16 == OFS_CTL2) && bus_i.wdata[CTL2_SWSYN_BIT]);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] rw;
    logic [15:0] fset;
    logic [15:0] fclr;
    rw   = REG_RST;
    fset = CTL_RST;
    fclr = CTL_RST;
    next_s = s;
    // pins only reach logic after two flops
    next_s.cap_sy = {s.cap_sy[1:0], capture_input_i};
    next_s.syn_sy = {s.syn_sy[1:0], sync_input_event_i};

    if (run) begin
      next_s.ctr = s.ctr + 32'h1;
      if (!pwm_mode && (s.ctr == 32'hffff_ffff)) begin
        fset[FLG_OVF_BIT] = 1'b1;
      end
    end
    if (prd_hit) begin
      next_s.ctr = REG_RST;
      fset[FLG_PRD_BIT] = 1'b1;
      // shadows become active at the period boundary
      next_s.slot[0] = s.slot[2];
      next_s.slot[1] = s.slot[3];
    end
    if (pwm_mode && run && (s.ctr == s.slot[1])) begin
      fset[FLG_CMP_BIT] = 1'b1;
    end
    if (evt) begin
      if (s.ctl1[CTL1_LDEN_BIT]) begin
        next_s.slot[ptr_idx] = s.ctr;
      end
      if (ev_rst) begin
        next_s.ctr = REG_RST;
      end
      fset[FLG_EVT_LSB + int'(ptr_idx)] = 1'b1;
      case (s.ptr)
        PTR_EV1: next_s.ptr = PTR_EV2;
        PTR_EV2: next_s.ptr = PTR_EV3;
        PTR_EV3: next_s.ptr = PTR_EV4;
        PTR_EV4: next_s.ptr = PTR_EV1;
        default: next_s.ptr = PTR_EV1;
      endcase
    end
    if (sync_load) begin
      next_s.ctr = s.phs;
    end

    // each bus access touches one 16-bit half
    if (bus_i.wr) begin
      if (wr_ctr) begin
        if (hi) next_s.ctr[31:16] = bus_i.wdata;
        else next_s.ctr[15:0] = bus_i.wdata;
      end
      if (a32 == OFS_PHS) begin
        if (hi) next_s.phs[31:16] = bus_i.wdata;
        else next_s.phs[15:0] = bus_i.wdata;
      end
      // slots at 8h upward, one word apart
      for (int i = 0; i < 4; i++) begin
        if (a32 == 7'(OFS_SLOT1 + 7'(4 * i))) begin
          // slots three and four only take the write
          if (hi) next_s.slot[i][31:16] = bus_i.wdata;
          else next_s.slot[i][15:0] = bus_i.wdata;
          // active write mirrored into the shadow
          if (pwm_mode && (i < 2)) begin
            if (hi) next_s.slot[i | 2][31:16] = bus_i.wdata;
            else next_s.slot[i | 2][15:0] = bus_i.wdata;
          end
        end
      end
      case (a16)
        OFS_CTL1: next_s.ctl1 = bus_i.wdata;
        OFS_CTL2: next_s.ctl2 = bus_i.wdata & CTL2_WMASK;
        OFS_IEN:  next_s.ien = bus_i.wdata;
        OFS_CLR:  fclr = bus_i.wdata;
        OFS_FRC:  fset = fset | bus_i.wdata;
        default:  fclr = CTL_RST;
      endcase
    end
    // a flag raised in the clearing cycle survives
    next_s.flg = (s.flg & ~fclr) | fset;

    if (bus_i.rd) begin
      case (a32)
        OFS_CTR:   rw = s.ctr;
        OFS_PHS:   rw = s.phs;
        OFS_SLOT1: rw = s.slot[0];
        OFS_SLOT2: rw = s.slot[1];
        OFS_SLOT3: rw = s.slot[2];
        OFS_SLOT4: rw = s.slot[3];
        OFS_REV:   rw = REVISION;
        default:   rw = REG_RST;
      endcase
      next_s.rdata = hi ? rw[31:16] : rw[15:0];
      case (a16)
        OFS_CTL1: next_s.rdata = s.ctl1;
        OFS_CTL2: next_s.rdata = s.ctl2;
        OFS_IEN:  next_s.rdata = s.ien;
        OFS_FLG:  next_s.rdata = s.flg;
        default:  next_s.rdata = next_s.rdata;
      endcase
    end else begin
      next_s.rdata = CTL_RST;
    end

    // high while below compare; inverted when active low
    next_s.pwm = pwm_mode && ((s.ctr < s.slot[1]) ^ s.ctl2[CTL2_POL_BIT]);
    case (s.ctl2[CTL2_SYNCO_LSB +: 2])
      SYNCO_PASS: next_s.sync = sync_evt;
      SYNCO_PRD:  next_s.sync = prd_hit;
      default:    next_s.sync = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s      <= '0;
      s.ptr  <= PTR_EV1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o          = s.rdata;
  assign pwm_output_pin_o = s.pwm;
  assign sync_output_o    = s.sync;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_mirror_period: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_i.wr && pwm_mode && (a32 == OFS_SLOT1) && !hi
    |=> s.slot[2][15:0] == $past(bus_i.wdata) && s.slot[0][15:0] == $past(bus_i.wdata))
    else $error("active period write not mirrored");

  a_shadow_only: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_i.wr && pwm_mode && (a32 == OFS_SLOT3) && !prd_hit |=> $stable(s.slot[0]))
    else $error("shadow write changed active period");

  a_pwm_high: assert property (@(posedge clk_i) disable iff (rst_i)
    pwm_mode && !s.ctl2[CTL2_POL_BIT] && (s.ctr == REG_RST) && (s.slot[1] != REG_RST)
    |=> pwm_output_pin_o)
    else $error("pwm not high at period start");

  a_pwm_low: assert property (@(posedge clk_i) disable iff (rst_i)
    pwm_mode && s.ctl2[CTL2_POL_BIT] && (s.ctr >= s.slot[1]) |=> pwm_output_pin_o)
    else $error("active low output wrong after compare");

  a_sync_period: assert property (@(posedge clk_i) disable iff (rst_i)
    prd_hit && (s.ctl2[CTL2_SYNCO_LSB +: 2] == SYNCO_PRD) |=> sync_output_o ##1 !sync_output_o)
    else $error("no sync pulse at period");

  a_edge_qual: assert property (@(posedge clk_i) disable iff (rst_i)
    !pwm_mode && run && (ev_pol ? rise : fall) |=> $stable(s.ptr))
    else $error("event taken on wrong edge");

  a_delta_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    evt && ev_rst && s.ctl1[CTL1_LDEN_BIT] && !sync_load && !bus_i.wr
    |=> s.ctr == REG_RST && s.slot[$past(ptr_idx)] == $past(s.ctr) && s.ptr != $past(s.ptr))
    else $error("delta capture order broken");

  a_phase_load: assert property (@(posedge clk_i) disable iff (rst_i)
    sync_load && !wr_ctr |=> s.ctr == $past(s.phs))
    else $error("phase offset not loaded");

  a_shadow_xfer: assert property (@(posedge clk_i) disable iff (rst_i)
    prd_hit && !bus_i.wr |=> s.slot[0] == $past(s.slot[2]) && s.slot[1] == $past(s.slot[3]))
    else $error("shadow transfer missing");

  a_pass_sync: assert property (@(posedge clk_i) disable iff (rst_i)
    sync_evt && (s.ctl2[CTL2_SYNCO_LSB +: 2] == SYNCO_PASS) |=> sync_output_o)
    else $error("sync-in not forwarded");

  a_rev_read: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_i.rd && (a32 == OFS_REV) && !hi |=> rdata_o == REVISION[15:0])
    else $error("revision low half wrong");

  a_mirror_compare: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_i.wr && pwm_mode && (a32 == OFS_SLOT2) && hi
    |=> s.slot[3][31:16] == $past(bus_i.wdata) && s.slot[1][31:16] == $past(bus_i.wdata))
    else $error("active compare write not mirrored");

  a_shadow_compare: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_i.wr && pwm_mode && (a32 == OFS_SLOT4) && !prd_hit |=> $stable(s.slot[1]))
    else $error("shadow write changed active compare");

  a_pwm_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !pwm_mode |=> !pwm_output_pin_o)
    else $error("pwm output active in capture mode");

  a_no_capture_pwm: assert property (@(posedge clk_i) disable iff (rst_i)
    pwm_mode |=> $stable(s.ptr))
    else $error("event taken in pwm mode");

  a_half_write: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_i.wr && (a32 == OFS_PHS) && hi
    |=> s.phs[31:16] == $past(bus_i.wdata) && s.phs[15:0] == $past(s.phs[15:0]))
    else $error("high half write disturbed low half");

  a_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus_i.rd |=> rdata_o == 16'h0)
    else $error("read data not idle");

  a_flag_force: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_i.wr && (a16 == OFS_FRC)
    |=> (s.flg & $past(bus_i.wdata)) == $past(bus_i.wdata))
    else $error("forced flag not set");

  a_ptr_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot(s.ptr))
    else $error("event pointer not one-hot");

  a_period_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    prd_hit && !sync_load && !wr_ctr |=> s.ctr == REG_RST)
    else $error("counter did not wrap at period");

endmodule

// ### test/cap_pulse_src.sv
`timescale 1ns/100ps
module cap_pulse_src (
  // clock
  input  wire logic       clk_i,
  // control
  input  wire logic       en_i,
  input  wire logic [7:0] high_i,
  input  wire logic [7:0] low_i,
  input  wire logic       sync_req_i,
  // pins
  output logic            pin_o,
  output logic            sync_o
);
  logic [7:0] cnt  = 8'h0;
  logic [1:0] hold = 2'h0;

  initial pin_o = 1'b0;

  // ------------------------------------------------------------
  // square wave, parked low while off
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!en_i) begin
      pin_o <= 1'b0;
      cnt   <= 8'h0;
    end else if (cnt + 8'h1 >= (pin_o ? high_i : low_i)) begin
      pin_o <= !pin_o;
      cnt   <= 8'h0;
    end else begin
      cnt <= cnt + 8'h1;
    end
  end

  // three cycles wide so the two-flop synchroniser cannot miss it
  always @(posedge clk_i) begin
    hold <= sync_req_i ? 2'h3 : hold - {1'b0, hold != 2'h0};
  end
  assign sync_o = hold != 2'h0;
endmodule

// ### test/tb.sv
`timescale 1ns/100ps
module tb;
  import cap_pkg::*;
  localparam logic [31:0] REV_VAL = 32'h0000_0a5c;  // arbitrary value
  logic            clk_i    = 1'b0;
  logic            rst_i    = 1'b1;
  cap_bus_req_type bus_i    = '0;
  logic            src_en   = 1'b0;
  logic            sync_req = 1'b0;
  logic [7:0]      hi       = 8'h7;
  logic [7:0]      lo       = 8'hc;
  logic            pend     = 1'b0;
  logic [15:0]     rdata_o;
  logic            pin, syn_in, pwm_o, syn_o;
  logic [31:0]     v;
  int              err_total = 0, total_checks = 0, syn_cnt = 0, s0, hi_cnt;
  logic [15:0]     exp_q[$];
  string           name_q[$];
  logic [6:0]      ofs[6] = '{OFS_CTR, OFS_PHS, OFS_SLOT1, OFS_SLOT2, OFS_SLOT3, OFS_SLOT4};

  cap_unit #(.REVISION(REV_VAL)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .capture_input_i(pin), .sync_input_event_i(syn_in),
    .pwm_output_pin_o(pwm_o), .sync_output_o(syn_o));
  cap_pulse_src u_src (.clk_i(clk_i), .en_i(src_en), .high_i(hi), .low_i(lo),
    .sync_req_i(sync_req), .pin_o(pin), .sync_o(syn_in));

  initial forever #20 clk_i = ~clk_i;

  // ------------------------------------------------------------
  // bus tasks and scoreboard
  // ------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [6:0] a, logic [15:0] d);
    @(posedge clk_i);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    bus_i <= '0;
  endtask
  task automatic rd(logic [6:0] a, logic [15:0] e, string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    @(posedge clk_i);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
    @(posedge clk_i);
    bus_i <= '0;
  endtask
  task automatic w32(logic [6:0] a, logic [31:0] d);
    wr(a, d[15:0]);
    wr(a + 7'h2, d[31:16]);
  endtask
  task automatic r32(logic [6:0] a, logic [31:0] e, string nm);
    rd(a, e[15:0], nm);
    rd(a + 7'h2, e[31:16], nm);
  endtask
  task automatic hcount(int n);
    hi_cnt = 0;
    repeat (n) begin
      @(posedge clk_i);
      hi_cnt += int'(pwm_o === 1'b1);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_i) begin
    pend    <= bus_i.rd;
    syn_cnt <= syn_cnt + int'(syn_o === 1'b1);
    if (pend && exp_q.size() > 0) chk(name_q.pop_front(), exp_q.pop_front(), rdata_o);
  end

  initial begin
    #(40 * 20000);
    err_total++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    v = $urandom(74);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ofs[i]) begin
      v = $urandom;
      w32(ofs[i], v);
      r32(ofs[i], v, "reg32");
    end
    wr(OFS_FRC, {8'h0, v[7:1], 1'b0});
    rd(OFS_FLG, {8'h0, v[7:1], 1'b0}, "flag force");
    wr(OFS_CLR, 16'h00fe);
    rd(OFS_FLG, 16'h0, "flag clear");
    v = $urandom;
    wr(OFS_CTL2, v[15:0]);
    rd(OFS_CTL2, v[15:0] & CTL2_WMASK, "ctl2");
    wr(OFS_CTL1, {7'h0, v[8:0]});
    rd(OFS_CTL1, {7'h0, v[8:0]}, "ctl1");
    wr(OFS_IEN, v[15:0] & 16'h00fe);
    rd(OFS_IEN, v[15:0] & 16'h00fe, "enable");
    r32(OFS_REV, REV_VAL, "revision");
    rd(7'h40, 16'h0, "unmapped");
    // delta capture, alternating edges, clear on every event
    hi <= 8'h4 + 8'($urandom % 8);
    lo <= 8'h4 + 8'($urandom % 8);
    wr(OFS_CTL2, 16'h0000);
    wr(OFS_CTL1, 16'h01ee);
    wr(OFS_CTL2, 16'h0010);
    src_en <= 1'b1;
    repeat (250) @(posedge clk_i);
    wr(OFS_CTL2, 16'h0000);
    src_en <= 1'b0;
    for (int i = 0; i < 4; i++) r32(ofs[i+2], 32'(i[0] ? hi : lo) - 32'h1, "delta");
    // sync-in with counter stopped, pass-through source
    v = $urandom;
    w32(OFS_PHS, v);
    w32(OFS_CTR, 32'h0);
    wr(OFS_CTL2, 16'h0020);
    s0 = syn_cnt;
    @(posedge clk_i);
    sync_req <= 1'b1;
    @(posedge clk_i);
    sync_req <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("sync pass", 16'h1, 16'(syn_cnt - s0));
    r32(OFS_CTR, v, "phase load");
    w32(OFS_CTR, 32'h0);
    wr(OFS_CTL2, 16'h0120);
    r32(OFS_CTR, v, "phase force");
    // source off: a sync-in pulse must not leave
    wr(OFS_CTL2, 16'h00a0);
    s0 = syn_cnt;
    @(posedge clk_i);
    sync_req <= 1'b1;
    @(posedge clk_i);
    sync_req <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("sync off", 16'h0, 16'(syn_cnt - s0));
    // pwm started through the active slots, updated through shadows
    wr(OFS_CTL2, 16'h0240);
    w32(OFS_SLOT1, 32'd9);
    w32(OFS_SLOT2, 32'd3);
    r32(OFS_SLOT3, 32'd9, "period shadow");
    r32(OFS_SLOT4, 32'd3, "compare shadow");
    w32(OFS_CTR, 32'h0);
    wr(OFS_CTL2, 16'h0250);
    repeat (5) @(posedge clk_i);
    s0 = syn_cnt;
    hcount(40);
    chk("high time", 16'd12, 16'(hi_cnt));
    chk("period sync", 16'd4, 16'(syn_cnt - s0));
    wr(OFS_CTL2, 16'h0650);
    repeat (5) @(posedge clk_i);
    hcount(40);
    chk("low time", 16'd28, 16'(hi_cnt));
    wr(OFS_CTL2, 16'h0240);
    w32(OFS_SLOT3, 32'd5);
    w32(OFS_SLOT4, 32'd2);
    r32(OFS_SLOT1, 32'd9, "period held");
    r32(OFS_SLOT2, 32'd3, "compare held");
    wr(OFS_CTL2, 16'h0250);
    repeat (20) @(posedge clk_i);
    r32(OFS_SLOT1, 32'd5, "period moved");
    r32(OFS_SLOT2, 32'd2, "compare moved");
    hcount(36);
    chk("new high time", 16'd12, 16'(hi_cnt));
    // reset in mid-run returns everything to idle
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    r32(OFS_CTR, REG_RST, "reset counter");
    rd(OFS_CTL2, CTL_RST, "reset control");
    chk("reset pwm", 16'h0, {15'h0, pwm_o});
    repeat (4) @(posedge clk_i);
    give_verdict();
  end
endmodule
